// ===== hw/bct_regs.vh
`ifndef BCT_REGS_VH
`define BCT_REGS_VH

// =====================================================================
// Operation codes handed over by the fetch stage.
`define BCT_OP_NOP 4'h0
`define BCT_OP_UNCOND 4'h1
`define BCT_OP_ON_CARRY 4'h2
`define BCT_OP_ON_NO_CARRY 4'h3
`define BCT_OP_ON_STATUS 4'h4
`define BCT_OP_ON_NO_STATUS 4'h5
`define BCT_OP_CALL 4'h6
`define BCT_OP_EXIT 4'h7
`define BCT_OP_RD_TIMER 4'h8
`define BCT_OP_RD_MOD_A 4'h9
`define BCT_OP_RD_MOD_B 4'ha
`define BCT_OP_WR_TIMER 4'hb
`define BCT_OP_WR_MOD_A 4'hc
`define BCT_OP_WR_MOD_B 4'hd
`define BCT_OP_LD_TIMER 4'he
`define BCT_OP_LD_MOD_B 4'hf

// =====================================================================
// Program counter layout: two page bits above a ten-bit local address.
`define BCT_PC_W 12
`define BCT_LOCAL_W 10
`define BCT_PC_RESET 12'h000
`define BCT_PC_STEP_ONE 12'h001
`define BCT_PC_STEP_TWO 12'h002
`define BCT_LOCAL_FIRST 10'h000
`define BCT_LOCAL_LAST 10'h3ff

// Page variant bits inside the first instruction word.
`define BCT_PAGE_LO_BIT 7
`define BCT_PAGE_HI_BIT 2

// =====================================================================
// Second-word operand layout: a9 a7 a6 a5 a4 a8 a3 a2 a1 a0.
`define BCT_OPD_A9 9
`define BCT_OPD_A8 4
`define BCT_OPD_MID_MSB 8
`define BCT_OPD_MID_LSB 5
`define BCT_OPD_LOW_MSB 3
`define BCT_OPD_LOW_LSB 0

// Ten-bit timer word nibble fields.
`define BCT_NIB_HI_MSB 9
`define BCT_NIB_HI_LSB 6
`define BCT_NIB_LO_MSB 5
`define BCT_NIB_LO_LSB 2
`define BCT_FORCE_HI_BIT 1
`define BCT_FORCE_LO_BIT 0
`define BCT_WORD_RESET 10'h000

// =====================================================================
// Timer interval in oscillator periods: (set + 1) * 64 - 4.
`define BCT_IVL_W 16
`define BCT_IVL_SHIFT 6
`define BCT_IVL_UNIT 16'h0040
`define BCT_IVL_LEAD 16'h0004
`define BCT_IVL_RESET 16'h0000

`endif

// ===== hw/bct_nibble_reg.v
`timescale 1ns/1ps
`include "bct_regs.vh"

module bct_nibble_reg #(
    parameter [9:0] RESET_VALUE = `BCT_WORD_RESET
) (
    input wire i_clock,
    input wire i_reset_n,
    input wire i_wr_hi,
    input wire i_wr_lo,
    input wire [3:0] i_nibble,
    input wire i_load,
    input wire [9:0] i_load_word,
    output wire [9:0] o_word
);

    reg [9:0] word_r;

    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            word_r <= RESET_VALUE;
        end else if (i_load) begin
            word_r <= i_load_word;
        end else if (i_wr_hi) begin
            word_r[`BCT_NIB_HI_MSB:`BCT_NIB_HI_LSB] <= i_nibble; // RL14
            word_r[`BCT_FORCE_HI_BIT] <= 1'b0; // RL14
        end else if (i_wr_lo) begin
            word_r[`BCT_NIB_LO_MSB:`BCT_NIB_LO_LSB] <= i_nibble; // RL14
            word_r[`BCT_FORCE_LO_BIT] <= 1'b0; // RL14
        end
    end

    assign o_word = word_r;

endmodule

// ===== hw/bct_interval.v
`timescale 1ns/1ps
`include "bct_regs.vh"

module bct_interval (
    input wire i_clock,
    input wire i_reset_n,
    input wire [9:0] i_set_value,
    output wire [15:0] o_periods
);

    reg [15:0] periods_r;
    wire [15:0] scaled;

    // Multiplying by 64 is a shift, so no multiplier is spent here.
    assign scaled = {i_set_value, {`BCT_IVL_SHIFT{1'b0}}};

    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            periods_r <= `BCT_IVL_RESET;
        end else begin
            periods_r <= scaled + `BCT_IVL_UNIT - `BCT_IVL_LEAD; // RL17
        end
    end

    assign o_periods = periods_r;

endmodule

// ===== hw/bct_exec.v
`timescale 1ns/1ps
`include "bct_regs.vh"

// Contract
// (RL1) Four pages of 1K local addresses.
// (RL2) Unconditional branch loads ten address bits.
// (RL3) Branch on carry set, else PC plus two.
// (RL4) Branch on carry clear, else PC plus two.
// (RL5) Branch on status set, else PC plus two.
// (RL6) Branch on status clear, else PC plus two.
// (RL7) Call: bump depth, save PC, load target.
// (RL8) Depth carry on call triggers internal reset.
// (RL9) Exit restores PC, then lowers depth.
// (RL10) Depth borrow on exit triggers internal reset.
// (RL11) Timer nibble read maps t9-t6, t5-t2.
// (RL12) Modulo A read uses same nibble map.
// (RL13) Modulo B read same map, clears carry.
// (RL14) Timer nibble write zeroes t1 or t0.
// (RL15) Modulo A write fills nibble, clears carry.
// (RL16) Modulo B write fills nibble, clears carry.
// (RL17) Interval is (set+1)*64 minus 4 periods.
// (RL18) Page bits come from first word variant.
// (RL19) Other reads take one cycle, PC plus one.
module bct_exec #(
    parameter SP_W = 1,
    parameter [SP_W-1:0] SP_RESET = {SP_W{1'b0}}
) (
    input wire i_clock,
    input wire i_reset_n,
    input wire i_instr_valid,
    input wire [3:0] i_op,
    input wire i_nibble_hi,
    input wire [9:0] i_word0,
    input wire [9:0] i_word1,
    input wire [3:0] i_acc,
    input wire i_carry_flag,
    input wire i_status_flag,
    output wire o_ready,
    output wire [11:0] o_pc,
    output wire [3:0] o_acc_data,
    output wire o_acc_load,
    output wire o_carry_clear,
    output wire o_internal_reset,
    output wire [SP_W-1:0] o_stack_depth_counter,
    output wire [11:0] o_saved_return_address,
    output wire [9:0] o_interval_count_word,
    output wire [9:0] o_modulo_word_a,
    output wire [9:0] o_modulo_word_b,
    output wire [15:0] o_timer_interval
);

    // =================================================================
    // State encoding.
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_CALL = 2'b10;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [11:0] pc_r;
    reg [11:0] pc_nxt;
    reg [SP_W-1:0] sp_r;
    reg [SP_W-1:0] sp_nxt;
    reg [11:0] asr_r;
    reg [11:0] asr_nxt;
    reg [11:0] target_r;
    reg [11:0] target_nxt;
    reg [3:0] acc_data_r;
    reg [3:0] acc_data_nxt;
    reg acc_load_r;
    reg acc_load_nxt;
    reg carry_clear_r;
    reg carry_clear_nxt;
    reg int_reset_r;
    reg int_reset_nxt;
    reg take_branch;
    reg wr_t_hi;
    reg wr_t_lo;
    reg wr_a_hi;
    reg wr_a_lo;
    reg wr_b_hi;
    reg wr_b_lo;
    reg ld_t;
    reg ld_b;

    wire take;
    wire [1:0] page;
    wire [9:0] local_addr;
    wire [11:0] branch_target;
    wire [9:0] imm_word;
    wire [SP_W:0] sp_inc;
    wire [SP_W:0] sp_dec;
    wire [9:0] t_word;
    wire [9:0] a_word;
    wire [9:0] b_word;

    // =================================================================
    // Operand decode.
    assign o_ready = state_r[0];
    assign take = i_instr_valid & state_r[0];

    // The page variant is carried in two bits of the first word.
    assign page = {i_word0[`BCT_PAGE_HI_BIT], ~i_word0[`BCT_PAGE_LO_BIT]}; // RL18

    // The operand word scatters a8 between the nibble fields.
    assign local_addr = {i_word1[`BCT_OPD_A9], i_word1[`BCT_OPD_A8],
                         i_word1[`BCT_OPD_MID_MSB:`BCT_OPD_MID_LSB],
                         i_word1[`BCT_OPD_LOW_MSB:`BCT_OPD_LOW_LSB]};

    assign branch_target = {page, local_addr}; // RL1

    // Immediate timer data uses t1 t9..t6 t0 t5..t2.
    assign imm_word = {i_word1[`BCT_OPD_MID_MSB:`BCT_OPD_MID_LSB],
                       i_word1[`BCT_OPD_LOW_MSB:`BCT_OPD_LOW_LSB],
                       i_word1[`BCT_OPD_A9], i_word1[`BCT_OPD_A8]};

    // One extra bit catches the carry or borrow out of the depth counter.
    assign sp_inc = {1'b0, sp_r} + {{SP_W{1'b0}}, 1'b1};
    assign sp_dec = {1'b0, sp_r} - {{SP_W{1'b0}}, 1'b1};

    // =================================================================
    // Branch condition.
    always @* begin
        take_branch = 1'b0;
        case (i_op)
            `BCT_OP_UNCOND: begin
                take_branch = 1'b1; // RL2
            end
            `BCT_OP_ON_CARRY: begin
                take_branch = i_carry_flag; // RL3
            end
            `BCT_OP_ON_NO_CARRY: begin
                take_branch = ~i_carry_flag; // RL4
            end
            `BCT_OP_ON_STATUS: begin
                take_branch = i_status_flag; // RL5
            end
            `BCT_OP_ON_NO_STATUS: begin
                take_branch = ~i_status_flag; // RL6
            end
            default: begin
                take_branch = 1'b0;
            end
        endcase
    end

    // =================================================================
    // Sequencer.
    always @* begin
        state_nxt = state_r;
        pc_nxt = pc_r;
        sp_nxt = sp_r;
        asr_nxt = asr_r;
        target_nxt = target_r;
        acc_data_nxt = acc_data_r;
        acc_load_nxt = 1'b0;
        carry_clear_nxt = 1'b0;
        int_reset_nxt = 1'b0;
        wr_t_hi = 1'b0;
        wr_t_lo = 1'b0;
        wr_a_hi = 1'b0;
        wr_a_lo = 1'b0;
        wr_b_hi = 1'b0;
        wr_b_lo = 1'b0;
        ld_t = 1'b0;
        ld_b = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (take) begin
                    pc_nxt = pc_r + `BCT_PC_STEP_ONE; // RL19
                    case (i_op)
                        `BCT_OP_UNCOND: begin
                            pc_nxt = {pc_r[11:10], local_addr}; // RL2
                            pc_nxt[11:10] = page; // RL18
                        end
                        `BCT_OP_ON_CARRY, `BCT_OP_ON_NO_CARRY,
                        `BCT_OP_ON_STATUS, `BCT_OP_ON_NO_STATUS: begin
                            if (take_branch) begin
                                pc_nxt = branch_target; // RL3 RL4 RL5 RL6
                            end else begin
                                pc_nxt = pc_r + `BCT_PC_STEP_TWO; // RL3 RL4 RL5 RL6
                            end
                        end
                        `BCT_OP_CALL: begin
                            sp_nxt = sp_inc[SP_W-1:0]; // RL7
                            asr_nxt = pc_r + `BCT_PC_STEP_TWO; // RL7
                            target_nxt = branch_target; // RL7
                            pc_nxt = pc_r;
                            state_nxt = ST_CALL; // RL7
                            int_reset_nxt = sp_inc[SP_W]; // RL8
                        end
                        `BCT_OP_EXIT: begin
                            pc_nxt = asr_r; // RL9
                            sp_nxt = sp_dec[SP_W-1:0]; // RL9
                            int_reset_nxt = sp_dec[SP_W]; // RL10
                        end
                        `BCT_OP_RD_TIMER: begin
                            acc_data_nxt = i_nibble_hi ? t_word[9:6] : t_word[5:2]; // RL11
                            acc_load_nxt = 1'b1; // RL19
                        end
                        `BCT_OP_RD_MOD_A: begin
                            acc_data_nxt = i_nibble_hi ? a_word[9:6] : a_word[5:2]; // RL12
                            acc_load_nxt = 1'b1; // RL19
                        end
                        `BCT_OP_RD_MOD_B: begin
                            acc_data_nxt = i_nibble_hi ? b_word[9:6] : b_word[5:2]; // RL13
                            acc_load_nxt = 1'b1; // RL13
                            carry_clear_nxt = 1'b1; // RL13
                        end
                        `BCT_OP_WR_TIMER: begin
                            wr_t_hi = i_nibble_hi; // RL14
                            wr_t_lo = ~i_nibble_hi; // RL14
                        end
                        `BCT_OP_WR_MOD_A: begin
                            wr_a_hi = i_nibble_hi; // RL15
                            wr_a_lo = ~i_nibble_hi; // RL15
                            carry_clear_nxt = 1'b1; // RL15
                        end
                        `BCT_OP_WR_MOD_B: begin
                            wr_b_hi = i_nibble_hi; // RL16
                            wr_b_lo = ~i_nibble_hi; // RL16
                            carry_clear_nxt = 1'b1; // RL16
                        end
                        `BCT_OP_LD_TIMER: begin
                            ld_t = 1'b1;
                        end
                        `BCT_OP_LD_MOD_B: begin
                            ld_b = 1'b1;
                        end
                        default: begin
                            pc_nxt = pc_r + `BCT_PC_STEP_ONE;
                        end
                    endcase
                end
            end
            ST_CALL: begin
                // Second call cycle: the target enters the counter.
                pc_nxt = target_r; // RL7
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        // An overflow or underflow restarts the core; stale targets are dropped.
        if (int_reset_r) begin
            state_nxt = ST_IDLE; // RL8 RL10
            pc_nxt = `BCT_PC_RESET; // RL8 RL10
            sp_nxt = SP_RESET; // RL8 RL10
        end
    end

    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r <= ST_IDLE;
            pc_r <= `BCT_PC_RESET;
            sp_r <= SP_RESET;
            asr_r <= `BCT_PC_RESET;
            target_r <= `BCT_PC_RESET;
            acc_data_r <= 4'h0;
            acc_load_r <= 1'b0;
            carry_clear_r <= 1'b0;
            int_reset_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pc_r <= pc_nxt;
            sp_r <= sp_nxt;
            asr_r <= asr_nxt;
            target_r <= target_nxt;
            acc_data_r <= acc_data_nxt;
            acc_load_r <= acc_load_nxt;
            carry_clear_r <= carry_clear_nxt;
            int_reset_r <= int_reset_nxt;
        end
    end

    // =================================================================
    // Timer and modulo words.
    bct_nibble_reg u_timer_word (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_wr_hi(wr_t_hi),
        .i_wr_lo(wr_t_lo),
        .i_nibble(i_acc),
        .i_load(ld_t),
        .i_load_word(imm_word),
        .o_word(t_word)
    );

    // Modulo A has no immediate load op in this group.
    bct_nibble_reg u_modulo_a (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_wr_hi(wr_a_hi),
        .i_wr_lo(wr_a_lo),
        .i_nibble(i_acc),
        .i_load(1'b0),
        .i_load_word(imm_word),
        .o_word(a_word)
    );

    bct_nibble_reg u_modulo_b (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_wr_hi(wr_b_hi),
        .i_wr_lo(wr_b_lo),
        .i_nibble(i_acc),
        .i_load(ld_b),
        .i_load_word(imm_word),
        .o_word(b_word)
    );

    bct_interval u_interval (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_set_value(t_word),
        .o_periods(o_timer_interval)
    );

    // =================================================================
    // Outputs.
    assign o_pc = pc_r;
    assign o_acc_data = acc_data_r;
    assign o_acc_load = acc_load_r;
    assign o_carry_clear = carry_clear_r;
    assign o_internal_reset = int_reset_r;
    assign o_stack_depth_counter = sp_r;
    assign o_saved_return_address = asr_r;
    assign o_interval_count_word = t_word;
    assign o_modulo_word_a = a_word;
    assign o_modulo_word_b = b_word;

endmodule

// ===== bench/bct_core_model.sv
`timescale 1ns/1ps
// ==========================================================
// Accumulator and carry flag of the core beside the block.
module bct_core_model (
    input wire i_clock,
    input wire i_reset_n,
    input wire i_flag_load,
    input wire [3:0] i_acc_value,
    input wire i_carry_value,
    input wire i_acc_load,
    input wire [3:0] i_acc_data,
    input wire i_carry_clear,
    output logic [3:0] o_acc,
    output logic o_carry_flag
);
    // A load from the bench wins over the block, so every test starts from known flags.
    always @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_acc <= 4'h0;
            o_carry_flag <= 1'b0;
        end else if (i_flag_load) begin
            o_acc <= i_acc_value;
            o_carry_flag <= i_carry_value;
        end else begin
            if (i_acc_load) o_acc <= i_acc_data;
            if (i_carry_clear) o_carry_flag <= 1'b0;
        end
    end
endmodule

// ===== bench/bct_exec_properties.sv
`timescale 1ns/1ps
`include "bct_regs.vh"
// ==========================================================
// Port-level checks of the execution block.
module bct_exec_checker #(
    parameter SP_W = 1,
    parameter [SP_W-1:0] SP_RESET = {SP_W{1'b0}}
) (
    input wire i_clock,
    input wire i_reset_n,
    input wire i_instr_valid,
    input wire [3:0] i_op,
    input wire i_nibble_hi,
    input wire [9:0] i_word0,
    input wire [9:0] i_word1,
    input wire [3:0] i_acc,
    input wire i_carry_flag,
    input wire i_status_flag,
    input wire o_ready,
    input wire [11:0] o_pc,
    input wire [3:0] o_acc_data,
    input wire o_acc_load,
    input wire o_carry_clear,
    input wire o_internal_reset,
    input wire [SP_W-1:0] o_stack_depth_counter,
    input wire [11:0] o_saved_return_address,
    input wire [9:0] o_interval_count_word,
    input wire [9:0] o_modulo_word_a,
    input wire [9:0] o_modulo_word_b,
    input wire [15:0] o_timer_interval
);
    // Requests in the internal reset pulse have their PC and depth update overridden, so they are left out.
    wire take = i_instr_valid && o_ready && !o_internal_reset;
    wire [11:0] tgt = {i_word0[2], ~i_word0[7], i_word1[9], i_word1[4],
        i_word1[8:5], i_word1[3:0]};
    wire [3:0] nib_b = i_nibble_hi ? o_modulo_word_b[9:6] : o_modulo_word_b[5:2];
    wire full = o_stack_depth_counter == {SP_W{1'b1}};
    wire empty = o_stack_depth_counter == {SP_W{1'b0}};
    wire cond = i_op >= `BCT_OP_ON_CARRY && i_op <= `BCT_OP_ON_NO_STATUS;
    wire jump = i_op == `BCT_OP_UNCOND || (i_op == `BCT_OP_ON_CARRY && i_carry_flag)
        || (i_op == `BCT_OP_ON_NO_CARRY && !i_carry_flag)
        || (i_op == `BCT_OP_ON_STATUS && i_status_flag)
        || (i_op == `BCT_OP_ON_NO_STATUS && !i_status_flag);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    sequence call_gap;
        !o_ready && o_saved_return_address == $past(o_pc) + `BCT_PC_STEP_TWO;
    endsequence
    sequence restart;
        o_pc == `BCT_PC_RESET && empty;
    endsequence
    chk_jump_taken: assert property (take && jump |=> o_pc == $past(tgt))
        else $error("branch target not loaded");
    chk_jump_skip: assert property (take && cond && !jump |=>
        o_pc == $past(o_pc) + `BCT_PC_STEP_TWO) else $error("skip not plus two");
    chk_call_steps: assert property (take && i_op == `BCT_OP_CALL && !full |=>
        call_gap ##1 o_pc == $past(tgt, 2)) else $error("call sequence wrong");
    chk_call_over: assert property (take && i_op == `BCT_OP_CALL && full |=>
        o_internal_reset ##1 restart) else $error("call overflow no reset");
    chk_exit_restore: assert property (take && i_op == `BCT_OP_EXIT && !empty |=>
        o_pc == $past(o_saved_return_address) && empty) else $error("exit restore wrong");
    chk_exit_under: assert property (take && i_op == `BCT_OP_EXIT && empty |=>
        o_internal_reset ##1 restart) else $error("exit underflow no reset");
    chk_read_mod_b: assert property (take && i_op == `BCT_OP_RD_MOD_B |=>
        o_acc_load && o_carry_clear && o_acc_data == $past(nib_b)) else $error("read b wrong");
    chk_timer_high: assert property (take && i_op == `BCT_OP_WR_TIMER && i_nibble_hi |=>
        o_interval_count_word[9:6] == $past(i_acc) && !o_interval_count_word[1] && !o_carry_clear)
        else $error("timer high write wrong");
    chk_mod_a_low: assert property (take && i_op == `BCT_OP_WR_MOD_A && !i_nibble_hi |=>
        o_modulo_word_a[5:2] == $past(i_acc) && !o_modulo_word_a[0] && o_carry_clear)
        else $error("modulo a low write wrong");
    chk_step_one: assert property (take && i_op >= `BCT_OP_RD_TIMER |=>
        o_pc == $past(o_pc) + `BCT_PC_STEP_ONE) else $error("pc not plus one");
    chk_interval_value: assert property ($past(i_reset_n) |-> o_timer_interval ==
        (16'h0000 + $past(o_interval_count_word) + 16'h0001) * `BCT_IVL_UNIT - `BCT_IVL_LEAD)
        else $error("interval wrong");
endmodule

bind bct_exec bct_exec_checker #(.SP_W(SP_W), .SP_RESET(SP_RESET)) u_chk (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_instr_valid(i_instr_valid), .i_op(i_op),
    .i_nibble_hi(i_nibble_hi), .i_word0(i_word0), .i_word1(i_word1), .i_acc(i_acc),
    .i_carry_flag(i_carry_flag), .i_status_flag(i_status_flag), .o_ready(o_ready),
    .o_pc(o_pc), .o_acc_data(o_acc_data), .o_acc_load(o_acc_load),
    .o_carry_clear(o_carry_clear), .o_internal_reset(o_internal_reset),
    .o_stack_depth_counter(o_stack_depth_counter),
    .o_saved_return_address(o_saved_return_address),
    .o_interval_count_word(o_interval_count_word), .o_modulo_word_a(o_modulo_word_a),
    .o_modulo_word_b(o_modulo_word_b), .o_timer_interval(o_timer_interval));

// ===== bench/testbench.sv
`timescale 1ns/1ps
`include "bct_regs.vh"
module testbench;
    logic i_clock = 0, i_reset_n = 0, i_instr_valid = 0, i_nibble_hi = 0, i_status_flag = 0;
    logic [3:0] i_op = 0, acc_v = 0;
    logic [9:0] i_word0 = 0, i_word1 = 0, t_e = 0, a_e = 0, b_e = 0;
    logic flag_ld = 0, cy_v = 0, sp_e = 0;
    logic [11:0] pc_e = 0, asr_e = 0;
    logic [5:0] notes[$];
    logic [5:0] nt;
    int fail_count = 0, compares = 0;
    wire [3:0] i_acc, o_acc_data;
    wire i_carry_flag, o_ready, o_acc_load, o_carry_clear, o_internal_reset, o_stack_depth_counter;
    wire [11:0] o_pc, o_saved_return_address;
    wire [9:0] o_interval_count_word, o_modulo_word_a, o_modulo_word_b;
    wire [15:0] o_timer_interval;
    bct_exec u_dut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_instr_valid(i_instr_valid),
        .i_op(i_op), .i_nibble_hi(i_nibble_hi), .i_word0(i_word0), .i_word1(i_word1),
        .i_acc(i_acc), .i_carry_flag(i_carry_flag), .i_status_flag(i_status_flag),
        .o_ready(o_ready), .o_pc(o_pc), .o_acc_data(o_acc_data), .o_acc_load(o_acc_load),
        .o_carry_clear(o_carry_clear), .o_internal_reset(o_internal_reset),
        .o_stack_depth_counter(o_stack_depth_counter),
        .o_saved_return_address(o_saved_return_address),
        .o_interval_count_word(o_interval_count_word), .o_modulo_word_a(o_modulo_word_a),
        .o_modulo_word_b(o_modulo_word_b), .o_timer_interval(o_timer_interval));
    bct_core_model u_core (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_flag_load(flag_ld),
        .i_acc_value(acc_v), .i_carry_value(cy_v), .i_acc_load(o_acc_load),
        .i_acc_data(o_acc_data), .i_carry_clear(o_carry_clear), .o_acc(i_acc),
        .o_carry_flag(i_carry_flag));
    initial begin
        forever #20 i_clock = ~i_clock;
    end
    // ==========================================================
    // Comparison helpers and the closing verdict.
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task final_report;
        chk("pending_notes", 16'h0000, 16'(notes.size()));
        if (fail_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    function [9:0] put(input [9:0] w, input h, input [3:0] a);
        put = w;
        if (h) put = {a, w[5:2], 1'b0, w[0]};
        else put = {w[9:6], a, w[1], 1'b0};
    endfunction
    function [3:0] get(input [9:0] w, input h);
        get = h ? w[9:6] : w[5:2];
    endfunction
    // ==========================================================
    // One instruction: flags loaded a cycle ahead, then offered while ready.
    task automatic issue(input [3:0] op, input hi, input [11:0] v, input [3:0] acc,
        input cy, input st);
        logic tk, ir;
        flag_ld = 1;
        acc_v = acc;
        cy_v = cy;
        @(negedge i_clock);
        flag_ld = 0;
        chk("pc", pc_e, o_pc);
        chk("depth", sp_e, o_stack_depth_counter);
        chk("timer", t_e, o_interval_count_word);
        chk("mod_a", a_e, o_modulo_word_a);
        chk("mod_b", b_e, o_modulo_word_b);
        chk("interval", ({6'h00, t_e} + 16'h0001) * 16'h0040 - 16'h0004, o_timer_interval);
        i_op = op;
        i_nibble_hi = hi;
        i_status_flag = st;
        i_word0 = 10'($urandom);
        i_word0[2] = v[11];
        i_word0[7] = ~v[10];
        if (op >= `BCT_OP_LD_TIMER) i_word1 = {v[1], v[9:6], v[0], v[5:2]};
        else i_word1 = {v[9], v[7:4], v[8], v[3:0]};
        i_instr_valid = 1;
        @(posedge i_clock);
        tk = op == 1 || (op == 2 && cy) || (op == 3 && !cy) || (op == 4 && st) || (op == 5 && !st);
        ir = (op == `BCT_OP_CALL && sp_e) || (op == `BCT_OP_EXIT && !sp_e);
        case (op)
            `BCT_OP_RD_TIMER: notes.push_back({2'b10, get(t_e, hi)});
            `BCT_OP_RD_MOD_A: notes.push_back({2'b10, get(a_e, hi)});
            `BCT_OP_RD_MOD_B: notes.push_back({2'b11, get(b_e, hi)});
            `BCT_OP_WR_TIMER: t_e = put(t_e, hi, acc);
            `BCT_OP_WR_MOD_A: a_e = put(a_e, hi, acc);
            `BCT_OP_WR_MOD_B: b_e = put(b_e, hi, acc);
            `BCT_OP_LD_TIMER: t_e = v[9:0];
            `BCT_OP_LD_MOD_B: b_e = v[9:0];
            default: ;
        endcase
        if (op == `BCT_OP_WR_MOD_A || op == `BCT_OP_WR_MOD_B) notes.push_back(6'h10);
        if (ir) {pc_e, sp_e} = 13'h0000;
        else if (op == `BCT_OP_CALL) {asr_e, sp_e, pc_e} = {pc_e + 12'h002, 1'b1, v};
        else if (op == `BCT_OP_EXIT) {pc_e, sp_e} = {asr_e, 1'b0};
        else if (op >= 1 && op <= 5) pc_e = tk ? v : pc_e + 12'h002;
        else pc_e = pc_e + 12'h001;
        @(negedge i_clock);
        i_instr_valid = 0;
        chk("reset_pulse", ir, o_internal_reset);
        if (op == `BCT_OP_CALL && !ir) begin
            chk("ready", 16'h0000, o_ready);
            chk("saved", asr_e, o_saved_return_address);
        end
    endtask
    // A pulse on load or clear is a result; the oldest note says what it should carry.
    always @(negedge i_clock) begin
        if (o_acc_load === 1'b1 || o_carry_clear === 1'b1) begin
            nt = notes.size() ? notes.pop_front() : 6'h00;
            chk("acc_result", nt, {o_acc_load, o_carry_clear, nt[5] ? o_acc_data : 4'h0});
        end
    end
    initial begin
        repeat (2000) @(posedge i_clock);
        chk("watchdog", 16'h0000, 16'h0001);
        final_report;
    end
    initial begin
        void'($urandom(2));
        repeat (20) @(posedge i_clock);
        @(negedge i_clock);
        i_reset_n = 1;
        issue(`BCT_OP_UNCOND, 0, 12'hbff, 4'h0, 0, 0);
        issue(`BCT_OP_UNCOND, 0, 12'h000, 4'h0, 0, 0);
        for (int k = 0; k < 20; k++) begin
            issue(4'(1 + k % 5), 0, {2'($urandom), 10'($urandom_range(0, 900))},
                4'($urandom), 1'((k / 5) % 2), 1'((k / 5) % 2));
        end
        repeat (2) begin
            issue(`BCT_OP_LD_TIMER, 0, 12'($urandom), 4'h0, 1, 0);
            issue(`BCT_OP_LD_MOD_B, 0, 12'($urandom), 4'h0, 1, 0);
            for (int op = 8; op <= 13; op++) begin
                for (int h = 0; h < 2; h++) issue(4'(op), 1'(h), 0, 4'($urandom), 1, 0);
            end
        end
        issue(`BCT_OP_CALL, 0, 12'h155, 4'h0, 0, 0);
        issue(`BCT_OP_CALL, 0, 12'h2aa, 4'h0, 0, 0);
        issue(`BCT_OP_CALL, 0, 12'h321, 4'h0, 0, 0);
        issue(`BCT_OP_EXIT, 0, 12'h000, 4'h0, 0, 0);
        issue(`BCT_OP_EXIT, 0, 12'h000, 4'h0, 0, 0);
        issue(`BCT_OP_NOP, 0, 12'h000, 4'h0, 0, 0);
        i_reset_n = 0;
        @(negedge i_clock);
        i_reset_n = 1;
        {pc_e, sp_e, t_e, a_e, b_e} = 43'h0;
        issue(`BCT_OP_NOP, 0, 12'h000, 4'h0, 0, 0);
        final_report;
    end
endmodule
